// >>> design/rsd_pkg.sv
// package of reset source distribution types and constants
`default_nettype none
package rsd_pkg;
  // ==========================================
  // source and unit counts
  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned NUM_UNIT = 8;
  // stretch length of each unit reset pulse, in cycles
  localparam logic [3:0] STRETCH_CYC = 4'h4;
  // rank shown when no ranked source stands, also the reset value
  localparam logic [2:0] RANK_NONE = 3'h7;
  // ==========================================
  // bit positions of sources in the source vector
  localparam int unsigned SRC_ALT = 0;
  localparam int unsigned SRC_PCI = 1;
  localparam int unsigned SRC_ISO = 2;
  localparam int unsigned SRC_D3D0 = 3;
  localparam int unsigned SRC_SWR = 4;
  localparam int unsigned SRC_SEL = 5;
  // ==========================================
  // bit positions of units in the unit vector
  localparam int unsigned U_EEP = 0;
  localparam int unsigned U_UCODE = 1;
  localparam int unsigned U_MAC = 2;
  localparam int unsigned U_PTR = 3;
  localparam int unsigned U_PCICFG = 4;
  localparam int unsigned U_PHY = 5;
  localparam int unsigned U_PME = 6;
  localparam int unsigned U_STAT = 7;
  // coverage masks per unit, bit order sel,swr,d3d0,iso,pci,alt
  localparam logic [5:0] COV_EEP = 6'h07;
  localparam logic [5:0] COV_UCODE = 6'h1b;
  localparam logic [5:0] COV_MAC = 6'h1f;
  localparam logic [5:0] COV_PTR = 6'h3b;
  localparam logic [5:0] COV_PCICFG = 6'h0f;
  localparam logic [5:0] COV_PHY = 6'h03;
  localparam logic [5:0] COV_PME = 6'h01;
  localparam logic [5:0] COV_STAT = 6'h1b;
  // ==========================================
  // carriers
  typedef logic [NUM_SRC-1:0] rsd_src_t;
  typedef logic [NUM_UNIT-1:0] rsd_unit_t;
  typedef struct packed {
    logic [3:0] cnt;
  } rsd_str_state_t;
  typedef enum logic [1:0] {
    RSD_IDLE = 2'b00,
    RSD_ACTIVE = 2'b01,
    RSD_HOLD = 2'b11
  } rsd_mode_t;
  typedef struct packed {
    rsd_mode_t mode;
    rsd_src_t src;
    logic [2:0] rank;
  } rsd_top_state_t;
endpackage
`default_nettype wire

// >>> design/rsd_stretch.sv
// one-unit reset stretcher holding reset for a minimum count
`default_nettype none
module rsd_stretch #(
  parameter logic [3:0] LEN = rsd_pkg::STRETCH_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic trig_in,
  output logic rst_out
);
  rsd_pkg::rsd_str_state_t st_ff;
  rsd_pkg::rsd_str_state_t nxt_st;
  // reload while trigger stands, else count down
  always_comb begin
    nxt_st = st_ff;
    if (trig_in) begin
      nxt_st.cnt = LEN;
    end else if (st_ff.cnt != 4'h0) begin
      nxt_st.cnt = st_ff.cnt - 4'h1;
    end
  end
  // asserted out of reset so units start cleared
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '{cnt: LEN};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rst_out = (st_ff.cnt != 4'h0);
endmodule
`default_nettype wire

// >>> design/rsd_top.sv
// reset source distribution top: maps sources onto unit resets
`default_nettype none
module rsd_top (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic ALTERNATE_HW_RESET_N_IN,
  input wire logic PCI_RST_N_IN,
  input wire logic BUS_ISOLATION_INPUT_N_IN,
  input wire logic D3_TO_D0_IN,
  input wire logic SW_RESET_IN,
  input wire logic SEL_RESET_IN,
  input wire logic AUX_POWER_IN,
  output logic [7:0] UNIT_RST_OUT,
  output logic [5:0] ACTIVE_SRC_OUT,
  output logic [2:0] TOP_SRC_OUT,
  output logic BUSY_OUT
);
  // ==========================================
  // source capture
  rsd_pkg::rsd_top_state_t st_ff;
  rsd_pkg::rsd_top_state_t nxt_st;
  rsd_pkg::rsd_src_t src_now;
  rsd_pkg::rsd_unit_t trig;
  logic [2:0] prio;
  // gather the six sources as active-high levels or pulses
  always_comb begin
    src_now = '0;
    src_now[rsd_pkg::SRC_ALT] = !ALTERNATE_HW_RESET_N_IN;
    src_now[rsd_pkg::SRC_PCI] = !PCI_RST_N_IN;
    src_now[rsd_pkg::SRC_ISO] = !BUS_ISOLATION_INPUT_N_IN;
    src_now[rsd_pkg::SRC_D3D0] = D3_TO_D0_IN;
    src_now[rsd_pkg::SRC_SWR] = SW_RESET_IN;
    src_now[rsd_pkg::SRC_SEL] = SEL_RESET_IN;
  end
  // ==========================================
  // coverage map: each unit but PME fires if any covering source is active
  always_comb begin
    trig = '0;
    trig[rsd_pkg::U_EEP] = |(src_now & rsd_pkg::COV_EEP);
    trig[rsd_pkg::U_UCODE] = |(src_now & rsd_pkg::COV_UCODE);
    trig[rsd_pkg::U_MAC] = |(src_now & rsd_pkg::COV_MAC);
    trig[rsd_pkg::U_PTR] = |(src_now & rsd_pkg::COV_PTR);
    trig[rsd_pkg::U_PCICFG] = |(src_now & rsd_pkg::COV_PCICFG);
    trig[rsd_pkg::U_PHY] = |(src_now & rsd_pkg::COV_PHY);
    trig[rsd_pkg::U_STAT] = |(src_now & rsd_pkg::COV_STAT);
    // aux power keeps wake state alive across a bus reset
    trig[rsd_pkg::U_PME] = src_now[rsd_pkg::SRC_ALT]
                         | (src_now[rsd_pkg::SRC_PCI] & !AUX_POWER_IN);
  end
  // ==========================================
  // precedence encode, for status only; resets themselves are a union
  always_comb begin
    prio = rsd_pkg::RANK_NONE;
    if (src_now[rsd_pkg::SRC_ALT]) begin
      prio = 3'h0;
    end else if (src_now[rsd_pkg::SRC_PCI]) begin
      prio = 3'h1;
    end else if (src_now[rsd_pkg::SRC_SWR]) begin
      prio = 3'h2;
    end else if (src_now[rsd_pkg::SRC_SEL]) begin
      prio = 3'h3;
    end
  end
  // ==========================================
  // per-unit stretchers give every unit a clean minimum pulse
  genvar gi;
  generate
    for (gi = 0; gi < rsd_pkg::NUM_UNIT; gi++) begin : g_unit
      rsd_stretch u_str (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .trig_in(trig[gi]),
        .rst_out(UNIT_RST_OUT[gi])
      );
    end
  endgenerate
  // ==========================================
  // status tracker: idle, active while sources stand, hold while stretching
  always_comb begin
    nxt_st = st_ff;
    nxt_st.src = src_now;
    nxt_st.rank = prio;
    case (st_ff.mode)
      rsd_pkg::RSD_IDLE: begin
        if (|src_now) begin
          nxt_st.mode = rsd_pkg::RSD_ACTIVE;
        end
      end
      rsd_pkg::RSD_ACTIVE: begin
        if (!(|src_now)) begin
          nxt_st.mode = rsd_pkg::RSD_HOLD;
        end
      end
      rsd_pkg::RSD_HOLD: begin
        if (|src_now) begin
          nxt_st.mode = rsd_pkg::RSD_ACTIVE;
        end else if (!(|UNIT_RST_OUT)) begin
          nxt_st.mode = rsd_pkg::RSD_IDLE;
        end
      end
      default: begin
        nxt_st.mode = rsd_pkg::RSD_IDLE;
      end
    endcase
  end
  // register the tracker; starts in hold since units come out in reset
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_ff <= '{mode: rsd_pkg::RSD_HOLD, src: '0, rank: rsd_pkg::RANK_NONE};
    end else begin
      st_ff <= nxt_st;
    end
  end
  // rank rides in the state word, so it stays aligned with the source copy
  assign ACTIVE_SRC_OUT = st_ff.src;
  assign TOP_SRC_OUT = st_ff.rank;
  assign BUSY_OUT = (st_ff.mode != rsd_pkg::RSD_IDLE);
  // ==========================================
  // checks
  sequence s_sel_only;
    SEL_RESET_IN && ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN && BUS_ISOLATION_INPUT_N_IN
      && !D3_TO_D0_IN && !SW_RESET_IN;
  endsequence
  // software command with no hardware source and no power-state event beside it
  sequence s_sw_cmd;
    SW_RESET_IN && ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN && BUS_ISOLATION_INPUT_N_IN
      && !D3_TO_D0_IN;
  endsequence
  sequence s_iso_only;
    !BUS_ISOLATION_INPUT_N_IN && ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN
      && !D3_TO_D0_IN && !SW_RESET_IN && !SEL_RESET_IN;
  endsequence
  sequence s_d3_cmd;
    D3_TO_D0_IN && ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN;
  endsequence
  // no source at all, so every stretcher just counts down
  sequence s_quiet;
    !(|src_now);
  endsequence
  AST_PTR_ON_SEL: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_sel_only |=> UNIT_RST_OUT[rsd_pkg::U_PTR]) else $error("pointer reset missing on sel");
  AST_ALT_ALL: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !ALTERNATE_HW_RESET_N_IN |=> (&UNIT_RST_OUT)) else $error("alt reset not all units");
  AST_PHY_ONLY: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    $rose(UNIT_RST_OUT[rsd_pkg::U_PHY]) |-> $past(trig[rsd_pkg::U_PHY]) &&
    $past(!ALTERNATE_HW_RESET_N_IN || !PCI_RST_N_IN)) else $error("phy reset bad source");
  AST_PME_AUX: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (!PCI_RST_N_IN && AUX_POWER_IN && ALTERNATE_HW_RESET_N_IN) |-> !trig[rsd_pkg::U_PME])
    else $error("pme cleared with aux power");
  AST_EEP_ISO: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !BUS_ISOLATION_INPUT_N_IN |=> UNIT_RST_OUT[rsd_pkg::U_EEP]) else $error("eep no iso");
  AST_EEP_SW: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (SW_RESET_IN || D3_TO_D0_IN) && ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN
      && BUS_ISOLATION_INPUT_N_IN |-> !trig[rsd_pkg::U_EEP]) else $error("eep by sw");
  AST_STAT_D3: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    D3_TO_D0_IN |=> UNIT_RST_OUT[rsd_pkg::U_STAT] && UNIT_RST_OUT[rsd_pkg::U_UCODE])
    else $error("stat or ucode missed d3");
  AST_MAC_SW: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    SW_RESET_IN |=> UNIT_RST_OUT[rsd_pkg::U_MAC] [*4]) else $error("mac pulse short");
  AST_PCI_SW: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_sw_cmd |-> !trig[rsd_pkg::U_PCICFG]) else $error("pci cfg by sw");
  AST_PCI_SEL: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_sel_only |-> !trig[rsd_pkg::U_PCICFG]) else $error("pci cfg by sel");
  AST_PRIO: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !ALTERNATE_HW_RESET_N_IN |=> TOP_SRC_OUT == 3'h0) else $error("alt not top");
  AST_UNION: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (!BUS_ISOLATION_INPUT_N_IN && SEL_RESET_IN) |=>
      UNIT_RST_OUT[rsd_pkg::U_PTR] && UNIT_RST_OUT[rsd_pkg::U_PCICFG])
    else $error("union lost");
  AST_SEL_ONLY: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_sel_only |-> !trig[rsd_pkg::U_EEP] && !trig[rsd_pkg::U_UCODE] && !trig[rsd_pkg::U_MAC]
      && !trig[rsd_pkg::U_PHY] && !trig[rsd_pkg::U_PME] && !trig[rsd_pkg::U_STAT])
    else $error("sel reset reached other units");
  // a lone pulse must not leave a unit stuck in reset past its stretch
  AST_PTR_END: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_sel_only ##1 s_quiet [*4] |=> !UNIT_RST_OUT[rsd_pkg::U_PTR])
    else $error("pointer reset outlived stretch");
  AST_ISO_UCODE: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_iso_only |-> !trig[rsd_pkg::U_UCODE] && !trig[rsd_pkg::U_STAT])
    else $error("iso touched ucode or stats");
  AST_ISO_PTR: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_iso_only |-> !trig[rsd_pkg::U_PTR]) else $error("iso touched pointers");
  AST_ISO_PHY: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_iso_only |-> !trig[rsd_pkg::U_PHY] && !trig[rsd_pkg::U_PME])
    else $error("iso touched phy or pme");
  AST_ISO_PCICFG: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !BUS_ISOLATION_INPUT_N_IN |=> UNIT_RST_OUT[rsd_pkg::U_PCICFG] && UNIT_RST_OUT[rsd_pkg::U_MAC])
    else $error("iso missed pci cfg or mac");
  AST_SW_PHY: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_sw_cmd |-> !trig[rsd_pkg::U_PHY] && !trig[rsd_pkg::U_PME]) else $error("sw touched phy");
  AST_D3_PHY: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    s_d3_cmd |-> !trig[rsd_pkg::U_PHY] && !trig[rsd_pkg::U_PME]) else $error("d3 touched phy");
  AST_D3_COVERS_SW: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    D3_TO_D0_IN |=> UNIT_RST_OUT[rsd_pkg::U_UCODE] && UNIT_RST_OUT[rsd_pkg::U_MAC]
      && UNIT_RST_OUT[rsd_pkg::U_PTR] && UNIT_RST_OUT[rsd_pkg::U_STAT])
    else $error("d3 missed a sw unit");
  AST_PCI_COVERS_SW: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !PCI_RST_N_IN |=> UNIT_RST_OUT[rsd_pkg::U_UCODE] && UNIT_RST_OUT[rsd_pkg::U_MAC]
      && UNIT_RST_OUT[rsd_pkg::U_PTR] && UNIT_RST_OUT[rsd_pkg::U_STAT]
      && UNIT_RST_OUT[rsd_pkg::U_PHY] && UNIT_RST_OUT[rsd_pkg::U_EEP])
    else $error("pci reset missed a unit");
  AST_PME_NOAUX: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (!PCI_RST_N_IN && !AUX_POWER_IN) |=> UNIT_RST_OUT[rsd_pkg::U_PME])
    else $error("pme kept without aux");
  AST_PME_OTHER: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    ALTERNATE_HW_RESET_N_IN && (PCI_RST_N_IN || AUX_POWER_IN) |-> !trig[rsd_pkg::U_PME])
    else $error("pme cleared by other source");
  AST_RANK_PCI: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    ALTERNATE_HW_RESET_N_IN && !PCI_RST_N_IN |=> TOP_SRC_OUT == 3'h1)
    else $error("pci not second");
  AST_RANK_SW: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN && SW_RESET_IN |=> TOP_SRC_OUT == 3'h2)
    else $error("sw not third");
  AST_RANK_SEL: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN && !SW_RESET_IN && SEL_RESET_IN
      |=> TOP_SRC_OUT == 3'h3)
    else $error("sel not fourth");
  AST_RANK_NONE: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    ALTERNATE_HW_RESET_N_IN && PCI_RST_N_IN && !SW_RESET_IN && !SEL_RESET_IN
      |=> TOP_SRC_OUT == rsd_pkg::RANK_NONE)
    else $error("unranked source shown");
  AST_UNION_D3_ISO: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    (D3_TO_D0_IN && !BUS_ISOLATION_INPUT_N_IN) |=>
      UNIT_RST_OUT[rsd_pkg::U_EEP] && UNIT_RST_OUT[rsd_pkg::U_PTR])
    else $error("d3 and iso union lost");
endmodule
`default_nettype wire

// >>> testbench/rsd_host.sv
// partner model: host reset and power logic driving the source lines
`default_nettype none
module rsd_host (
  input wire logic [5:0] req_in,
  input wire logic aux_in,
  output logic alt_n_out,
  output logic pci_n_out,
  output logic iso_n_out,
  output logic d3d0_out,
  output logic swr_out,
  output logic sel_out,
  output logic aux_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // pin levels; low-true pins idle high, like their pull-ups
  assign alt_n_out = ~req_in[0];
  assign pci_n_out = ~req_in[1];
  assign iso_n_out = ~req_in[2];
  assign d3d0_out = req_in[3];
  assign swr_out = req_in[4];
  assign sel_out = req_in[5];
  assign aux_out = aux_in; // supply indicator is a plain level
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the reset source distribution top
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic aux = 1'b0;
  logic [5:0] req = 6'h00;
  logic alt_n, pci_n, iso_n, d3d0, swr, sel, aux_p, busy;
  logic [7:0] unit_rst;
  logic [5:0] act_src;
  logic [2:0] top_src;
  logic [31:0] r;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 86861;
  // ==========================================
  // harness
  rsd_host u_rsd_host (.req_in(req), .aux_in(aux), .alt_n_out(alt_n), .pci_n_out(pci_n),
    .iso_n_out(iso_n), .d3d0_out(d3d0), .swr_out(swr), .sel_out(sel), .aux_out(aux_p));
  rsd_top u_rsd_top (.CLK_IN(clk), .ARST_N_IN(arst_n), .ALTERNATE_HW_RESET_N_IN(alt_n),
    .PCI_RST_N_IN(pci_n), .BUS_ISOLATION_INPUT_N_IN(iso_n), .D3_TO_D0_IN(d3d0),
    .SW_RESET_IN(swr), .SEL_RESET_IN(sel), .AUX_POWER_IN(aux_p), .UNIT_RST_OUT(unit_rst),
    .ACTIVE_SRC_OUT(act_src), .TOP_SRC_OUT(top_src), .BUSY_OUT(busy));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // expectations; source bits alt,pci,iso,d3d0,sw,sel
  function automatic logic [7:0] cover_of(input logic [5:0] s, input logic a);
    logic [7:0] u;
    u = 8'h00;
    if (s[0] | s[1]) u = 8'hff;
    if (s[1] & ~s[0] & a) u[6] = 1'b0; // event state kept on aux power
    if (s[2]) u = u | 8'h15;
    if (s[3]) u = u | 8'h9e;
    if (s[4]) u = u | 8'h8e;
    if (s[5]) u = u | 8'h08;
    return u;
  endfunction
  function automatic logic [2:0] rank_of(input logic [5:0] s);
    return s[0] ? 3'h0 : s[1] ? 3'h1 : s[4] ? 3'h2 : s[5] ? 3'h3 : rsd_pkg::RANK_NONE;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle pulse, then follow the stretch down to idle
  task automatic apply(input logic [5:0] s, input logic a);
    @(posedge clk);
    #1;
    req = s;
    aux = a;
    @(posedge clk);
    #1;
    req = 6'h00;
    #1;
    chk(unit_rst, cover_of(s, a));
    chk({2'h0, act_src}, {2'h0, s});
    chk({5'h00, top_src}, {5'h00, rank_of(s)});
    chk({7'h00, busy}, {7'h00, |s});
    repeat (3) @(posedge clk);
    #2;
    chk(unit_rst, cover_of(s, a));
    chk({7'h00, busy}, {7'h00, |s});
    @(posedge clk);
    #2;
    chk(unit_rst, 8'h00);
    @(posedge clk);
    #2;
    chk({7'h00, busy}, 8'h00);
  endtask
  // hold reset, check its values, then follow the release stretch to idle
  task automatic do_reset(input int cycles);
    arst_n = 1'b0;
    repeat (cycles) @(posedge clk);
    #1;
    chk(unit_rst, 8'hff);
    chk({2'h0, act_src}, 8'h00);
    chk({5'h00, top_src}, {5'h00, rsd_pkg::RANK_NONE});
    chk({7'h00, busy}, 8'h01);
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(unit_rst, 8'hff);
    @(posedge clk);
    #1;
    chk(unit_rst, 8'h00);
    chk({7'h00, busy}, 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence: singles on both supplies, then random overlaps
  initial begin
    do_reset(16);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      apply(6'h01 << (i % 6), i >= 6);
    end
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      apply(r[5:0], r[6]);
    end
    // mid-run reset, then corners: every source, bus reset without aux, d3 with sw
    @(posedge clk);
    #1;
    do_reset(4);
    apply(6'h3f, 1'b1);
    apply(6'h02, 1'b0);
    apply(6'h18, 1'b1);
    conclude();
  end
  // watchdog sized well past the expected run
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
